/* File: core/dcr_pkg.sv */
// Shared constants of the memory controller configuration register bank
package dcr_pkg;
  // Byte offsets
  localparam logic [7:0] DCR_OFS_IDENT   = 8'h00;
  localparam logic [7:0] DCR_OFS_STATUS  = 8'h04;
  localparam logic [7:0] DCR_OFS_CFG     = 8'h08;
  localparam logic [7:0] DCR_OFS_REFRESH = 8'h0c;
  localparam logic [7:0] DCR_OFS_TIM1    = 8'h10;
  localparam logic [7:0] DCR_OFS_TIM2    = 8'h14;
  localparam logic [7:0] DCR_OFS_BURST_PRIORITY   = 8'h20;
  localparam logic [7:0] DCR_OFS_CTRL    = 8'he4;
  // Identity values, arbitrary
  localparam logic [13:0] DCR_MODULE_IDENTIFIER = 14'h0123;
  localparam logic [7:0]  DCR_MAJOR_REVISION    = 8'h01;
  localparam logic [7:0]  DCR_MINOR_REVISION    = 8'h00;
  // Configuration and status field positions
  localparam int DCR_CFG_BOOT_UNLOCK = 23;
  localparam int DCR_CFG_DRIVE       = 18;
  localparam int DCR_CFG_TIM_WE      = 15;
  localparam int DCR_CFG_BUS_WIDTH   = 14;
  localparam int DCR_STAT_READY      = 2;
  localparam int DCR_STAT_ONE        = 30;
  // Reset values
  localparam logic [2:0] DCR_RST_CAS       = 3'h5;
  localparam logic [2:0] DCR_RST_BANK      = 3'h2;
  localparam logic [2:0] DCR_RST_ROW       = 3'h0;
  localparam logic [3:0] DCR_RST_HI_RSV    = 4'ha;
  localparam logic [1:0] DCR_RST_LO_RSV    = 2'h3;
  localparam logic [31:0] DCR_RST_REFRESH  = 32'h0000_081e;
  localparam logic [31:0] DCR_RST_TIM1     = 32'h0000_0000;
  localparam logic [31:0] DCR_RST_TIM2     = 32'h0000_0000;
  localparam logic [31:0] DCR_RST_BURST_PRIORITY    = 32'h0000_00ff;
  // Control: bit 5 interface reset, bits 2:0 read latency
  localparam int         DCR_CTRL_IFRST    = 5;
  localparam logic [2:0] DCR_RST_RL        = 3'h6;
  // Initialization sequence length and PHY lock time in cycles
  localparam logic [7:0] DCR_INIT_CYCLES   = 8'hc8;
  localparam logic [3:0] DCR_LOCK_CYCLES   = 4'h8;
  // Read latency shift depth
  localparam int         DCR_RL_DEPTH      = 8;
endpackage

/* File: core/dcr_rd_if.sv */
// Carrier between register bank and read data sampler
`timescale 1ns/10ps
interface dcr_rd_if;
  logic       issue;   // Read command issued
  logic [2:0] latency; // Programmed read latency
  logic       sample;  // Sample returning data now
  modport bank (output issue, output latency, input sample);
  modport smp  (input issue, input latency, output sample);
endinterface

/* File: core/dcr_rd_sampler.sv */
// Delays a read command by the programmed read latency plus two cycles to time data capture
`timescale 1ns/10ps
module dcr_rd_sampler
  import dcr_pkg::*;
(
  input  wire logic clk, // Clock
  input  wire logic rst, // Sync reset
  dcr_rd_if.smp     rd   // Issue in, sample out
);
  logic [DCR_RL_DEPTH-1:0] pipe_r;
  logic                    sample_r;

  // Shift register of issued reads
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= {pipe_r[DCR_RL_DEPTH-2:0], rd.issue};
    end
  end

  // Tap chosen by read latency
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= pipe_r[rd.latency];
    end
  end

  assign rd.sample = sample_r;
endmodule

/* File: core/dcr_regs.sv */
// AHB-Lite configuration and status register bank of the DDR2 memory controller
// Notes on behaviour
// - Read data is sampled at the cycle set by read latency.
// - Interface reset field at zero releases the interface logic.
// - Identity register returns identifier, major and minor revision, read-only.
// - Reserved read-zero bits read zero and ignore writes.
// - Status bit 30 always reads one and ignores writes.
// - Status bit 2 reads one only when interface is powered, locked, ready.
// - Configuration bits 14:0 are writable only while timing write enable is set.
// - Boot unlock bit 23 gates writes to bits 22:16.
// - Bit 18 selects weak drive; writable only when boot unlocked.
// - Bit 15 gates writes to both timing registers.
// - Writing bit 15 or bit 14 starts SDRAM initialization.
// - Bit 14 selects 16-bit bus when one, 32-bit when zero.
`timescale 1ns/10ps
module dcr_regs
  import dcr_pkg::*;
(
  input  wire logic        clk,          // Clock, 125 MHz
  input  wire logic        rst,          // Sync reset, active high
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [2:0]  hsize,        // Transfer size
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready in
  output logic      [31:0] hrdata,       // Read data
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Response, always OKAY
  input  wire logic        phy_powered,  // Interface powered, from pin
  input  wire logic        phy_locked,   // Interface DLL locked, from pin
  input  wire logic        rd_request,   // Core asks to issue a read
  output logic             rd_issue,     // Read command issued
  output logic             rd_sample,    // Capture read data now
  output logic             init_active,  // Initialization sequence running
  output logic             phy_reset,    // Interface logic held in reset
  output logic             bus_16bit,    // External bus is 16 bits
  output logic             drive_weak    // Weak drive strength
);
  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic        ph_write_r;
  logic [7:0]  ph_addr_r;
  logic        boot_unlock_r;
  logic [3:0]  hi_rsv_r;
  logic        drive_r;
  logic [1:0]  lo_rsv_r;
  logic        tim_we_r;
  logic        bus_width_select_r;
  logic [2:0]  cas_latency_r;
  logic [2:0]  bank_count_select_r;
  logic [2:0]  row_width_select_r;
  logic [31:0] refresh_r;
  logic [31:0] tim1_r;
  logic [31:0] tim2_r;
  logic [31:0] burst_priority_r;
  logic        phy_interface_reset_r;
  logic [2:0]  read_latency_r;
  logic [31:0] hrdata_r;
  logic        pw_m_r;
  logic        pw_s_r;
  logic        lk_m_r;
  logic        lk_s_r;
  logic [3:0]  lock_cnt_r;
  logic        ready_r;
  logic [7:0]  init_cnt_r;
  logic        init_r;
  logic        issue_r;
  logic        sample_q_r;
  logic        wr_cfg;
  logic        wr_ctrl;
  logic        init_start;
  logic        ph_valid;
  logic [31:0] cfg_view;
  logic [31:0] rd_mux;
  logic [7:0]  ap_ofs;

  typedef enum logic [2:0] {
    DCR_ST_IDLE = 3'b001,
    DCR_ST_INIT = 3'b010,
    DCR_ST_RUN  = 3'b100
  } dcr_state_type;
  dcr_state_type st_r;

  dcr_rd_if rdc ();

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, OKAY always
  assign ph_valid = hsel && hready && htrans[1];

  // Address phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_write_r <= 1'b0;
      ph_addr_r  <= 8'h00;
    end else begin
      ph_write_r <= ph_valid && hwrite;
      ph_addr_r  <= ap_ofs;
    end
  end

  assign wr_cfg  = ph_write_r && (ph_addr_r == DCR_OFS_CFG);
  assign wr_ctrl = ph_write_r && (ph_addr_r == DCR_OFS_CTRL);

  // Bus handshake outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register upper half, bits 22:16 gated by boot unlock
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_unlock_r <= 1'b0;
      hi_rsv_r      <= DCR_RST_HI_RSV;
      drive_r       <= 1'b0;
      lo_rsv_r      <= DCR_RST_LO_RSV;
    end else if (wr_cfg) begin
      boot_unlock_r <= hwdata[DCR_CFG_BOOT_UNLOCK];
      // Gate uses the stored unlock, so unlock and change take two writes
      if (boot_unlock_r) begin
        hi_rsv_r <= hwdata[22:19];
        drive_r  <= hwdata[DCR_CFG_DRIVE];
        lo_rsv_r <= hwdata[17:16];
      end
    end
  end

  // Configuration lower half. Timing write enable always writable so it can unlock.
  // The lock polarity follows the field meaning: one is unlocked.
  always_ff @(posedge clk) begin
    if (rst) begin
      tim_we_r            <= 1'b0;
      bus_width_select_r  <= 1'b0;
      cas_latency_r       <= DCR_RST_CAS;
      bank_count_select_r <= DCR_RST_BANK;
      row_width_select_r  <= DCR_RST_ROW;
    end else if (wr_cfg) begin
      tim_we_r <= hwdata[DCR_CFG_TIM_WE];
      if (tim_we_r) begin
        bus_width_select_r  <= hwdata[DCR_CFG_BUS_WIDTH];
        cas_latency_r       <= hwdata[11:9];
        bank_count_select_r <= hwdata[6:4];
        row_width_select_r  <= hwdata[2:0];
      end
    end
  end

  // Reserved bits 31:24, 13:12, 8:7, 3 read zero
  assign cfg_view = {8'h00, boot_unlock_r, hi_rsv_r, drive_r, lo_rsv_r, tim_we_r,
                     bus_width_select_r, 2'b00, cas_latency_r, 2'b00, bank_count_select_r,
                     1'b0, row_width_select_r};

  //////////////////////////////////////////////////////////////////////////////
  // Refresh, priority and timing registers
  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_r <= DCR_RST_REFRESH;
      burst_priority_r   <= DCR_RST_BURST_PRIORITY;
    end else begin
      if (ph_write_r && ph_addr_r == DCR_OFS_REFRESH) begin
        refresh_r <= hwdata;
      end
      if (ph_write_r && ph_addr_r == DCR_OFS_BURST_PRIORITY) begin
        burst_priority_r <= hwdata;
      end
    end
  end

  // Timing registers change only while timing write enable is set
  always_ff @(posedge clk) begin
    if (rst) begin
      tim1_r <= DCR_RST_TIM1;
      tim2_r <= DCR_RST_TIM2;
    end else if (tim_we_r) begin
      if (ph_write_r && ph_addr_r == DCR_OFS_TIM1) begin
        tim1_r <= hwdata;
      end
      if (ph_write_r && ph_addr_r == DCR_OFS_TIM2) begin
        tim2_r <= hwdata;
      end
    end
  end

  // Control register: interface reset and read latency
  always_ff @(posedge clk) begin
    if (rst) begin
      phy_interface_reset_r <= 1'b1;
      read_latency_r        <= DCR_RST_RL;
    end else if (wr_ctrl) begin
      phy_interface_reset_r <= hwdata[DCR_CTRL_IFRST];
      read_latency_r        <= hwdata[2:0]; // Expected CAS latency plus one
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interface readiness: pins synchronised, then lock must hold for a while
  always_ff @(posedge clk) begin
    if (rst) begin
      pw_m_r <= 1'b0;
      pw_s_r <= 1'b0;
      lk_m_r <= 1'b0;
      lk_s_r <= 1'b0;
    end else begin
      pw_m_r <= phy_powered;
      pw_s_r <= pw_m_r;
      lk_m_r <= phy_locked;
      lk_s_r <= lk_m_r;
    end
  end

  // Zero in interface reset lets the logic run
  always_ff @(posedge clk) begin
    if (rst || phy_interface_reset_r || !pw_s_r || !lk_s_r) begin
      lock_cnt_r <= 4'h0;
      ready_r    <= 1'b0;
    end else if (lock_cnt_r != DCR_LOCK_CYCLES) begin
      lock_cnt_r <= lock_cnt_r + 4'h1;
      ready_r    <= 1'b0;
    end else begin
      ready_r    <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Initialization sequencer
  assign init_start = wr_cfg; // Every config write touches bits 15 and 14

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r       <= DCR_ST_IDLE;
      init_cnt_r <= 8'h00;
    end else if (init_start) begin
      st_r       <= DCR_ST_INIT;
      init_cnt_r <= 8'h00;
    end else begin
      unique case (st_r)
        DCR_ST_IDLE: begin
          if (ready_r) begin
            st_r <= DCR_ST_INIT;
          end
        end
        DCR_ST_INIT: begin
          if (!ready_r) begin
            init_cnt_r <= 8'h00; // Sequence cannot proceed without the interface
          end else if (init_cnt_r == DCR_INIT_CYCLES) begin
            st_r <= DCR_ST_RUN;
          end else begin
            init_cnt_r <= init_cnt_r + 8'h01;
          end
        end
        DCR_ST_RUN: begin
          if (!ready_r) begin
            st_r <= DCR_ST_IDLE;
          end
        end
        default: st_r <= DCR_ST_IDLE;
      endcase
    end
  end

  // Reads only issue after init on a ready interface
  always_ff @(posedge clk) begin
    if (rst) begin
      issue_r <= 1'b0;
    end else begin
      issue_r <= rd_request && ready_r && (st_r == DCR_ST_RUN) && !init_start;
    end
  end

  assign rdc.issue   = issue_r;
  assign rdc.latency = read_latency_r;

  dcr_rd_sampler u_sampler (
    .clk (clk),
    .rst (rst),
    .rd  (rdc)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address phase offset; aliases fall on an unmapped word
  assign ap_ofs = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hfc;

  // Read data mux on the live address; bit 31 of status reads zero, bit 30 reads one
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ap_ofs)
      DCR_OFS_IDENT:   rd_mux = {2'b00, DCR_MODULE_IDENTIFIER, DCR_MAJOR_REVISION, DCR_MINOR_REVISION};
      DCR_OFS_STATUS:  begin
        rd_mux[DCR_STAT_ONE]   = 1'b1;
        rd_mux[DCR_STAT_READY] = ready_r;
      end
      DCR_OFS_CFG:     rd_mux = cfg_view;
      DCR_OFS_REFRESH: rd_mux = refresh_r;
      DCR_OFS_TIM1:    rd_mux = tim1_r;
      DCR_OFS_TIM2:    rd_mux = tim2_r;
      DCR_OFS_BURST_PRIORITY:   rd_mux = burst_priority_r;
      DCR_OFS_CTRL:    rd_mux = {26'h0, phy_interface_reset_r, 2'b00, read_latency_r};
      default:         rd_mux = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  // Read data registered at the address phase so it stands in the data phase
  always_comb begin
    hrdata = hrdata_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= 32'h0000_0000;
      if (ph_valid && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered side outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_issue    <= 1'b0;
      sample_q_r  <= 1'b0;
      init_active <= 1'b0;
      phy_reset   <= 1'b1;
      bus_16bit   <= 1'b0;
      drive_weak  <= 1'b0;
    end else begin
      rd_issue    <= issue_r;
      sample_q_r  <= rdc.sample;
      init_active <= (st_r == DCR_ST_INIT);
      phy_reset   <= phy_interface_reset_r;
      bus_16bit   <= bus_width_select_r;
      drive_weak  <= drive_r;
    end
  end

  assign rd_sample = sample_q_r;

  // Bit 31 of status is never stored, so a stray one has no effect here
  // Reserved config fields are stored as written under boot unlock
endmodule

/* File: dv/dcr_regs_monitor.sv */
// Checker of bus answers, lock gating and command gating of the register bank
`timescale 1ns/10ps
module dcr_regs_monitor
  import dcr_pkg::*;
(
  input wire logic        clk,         // Clock
  input wire logic        rst,         // Sync reset
  input wire logic        hsel,        // Slave select
  input wire logic [31:0] haddr,       // Address
  input wire logic [1:0]  htrans,      // Transfer type
  input wire logic        hwrite,      // Write when high
  input wire logic [31:0] hwdata,      // Write data
  input wire logic        hready,      // Bus ready in
  input wire logic [31:0] hrdata,      // Read data
  input wire logic        hreadyout,   // Slave ready
  input wire logic        hresp,       // Response
  input wire logic        phy_reset,   // Interface in reset
  input wire logic        rd_issue,    // Read issued
  input wire logic        init_active, // Init running
  input wire logic        bus_16bit,   // Narrow bus
  input wire logic        drive_weak   // Weak drive
);
  logic       dph_r;
  logic       dwr_r;
  logic       dhi_r;
  logic       tim_we_r;
  logic       boot_r;
  logic [7:0] dad_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Remember each taken address phase for its data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      dph_r <= 1'b0;
    end else begin
      dph_r <= hsel && hready && htrans[1];
    end
    dwr_r <= hwrite;
    dad_r <= haddr[7:0];
    dhi_r <= |haddr[31:8];
  end
  // Mirror the lock bits, which always accept writes
  always_ff @(posedge clk) begin
    if (rst) begin
      tim_we_r <= 1'b0;
      boot_r   <= 1'b0;
    end else if (dph_r && dwr_r && !dhi_r && dad_r == DCR_OFS_CFG) begin
      tim_we_r <= hwdata[15];
      boot_r   <= hwdata[23];
    end
  end
  wire rd_ph = dph_r && !dwr_r;
  wire hit   = !dhi_r && (dad_r inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'he4});
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    dph_r && dwr_r && !dhi_r && dad_r == DCR_OFS_CFG;
  endsequence
  sequence s_ctl_wr;
    dph_r && dwr_r && !dhi_r && dad_r == DCR_OFS_CTRL;
  endsequence
  // Gated bits take the new value only when the stored lock bit allows it;
  // the pins follow two edges after the data phase (field flop, then output flop)
  wire exp_bw  = tim_we_r ? hwdata[DCR_CFG_BUS_WIDTH] : bus_16bit;
  wire exp_dw  = boot_r ? hwdata[DCR_CFG_DRIVE] : drive_weak;
  wire exp_prs = hwdata[DCR_CTRL_IFRST];
  property p_width;
    s_cfg_wr |-> ##2 (bus_16bit == $past(exp_bw, 2));
  endproperty
  property p_drive;
    s_cfg_wr |-> ##2 (drive_weak == $past(exp_dw, 2));
  endproperty
  property p_phyrst;
    s_ctl_wr |-> ##2 (phy_reset == $past(exp_prs, 2));
  endproperty
  bus_okay_a: assert property (hreadyout && !hresp) else $error("slave not ready or not okay");
  ident_read_a: assert property (rd_ph && hit && dad_r == DCR_OFS_IDENT |-> hrdata ==
    {2'h0, DCR_MODULE_IDENTIFIER, DCR_MAJOR_REVISION, DCR_MINOR_REVISION}) else $error("identity wrong");
  status_fixed_a: assert property (rd_ph && hit && dad_r == DCR_OFS_STATUS |->
    hrdata[31:30] == 2'h1 && hrdata[29:3] == '0 && hrdata[1:0] == 2'h0) else $error("status fixed bits wrong");
  unmapped_zero_a: assert property (rd_ph && !hit |-> hrdata == 32'h0) else $error("unmapped read not zero");
  idle_zero_a: assert property (!rd_ph |-> hrdata == 32'h0) else $error("read data outside data phase");
  width_gate_a: assert property (p_width) else $error("bus width gating wrong");
  drive_gate_a: assert property (p_drive) else $error("drive strength gating wrong");
  phy_release_a: assert property (p_phyrst) else $error("interface reset not following control");
  init_start_a: assert property (s_cfg_wr |-> ##[1:3] init_active) else $error("no init after write");
  init_quiet_a: assert property (rd_issue |-> !init_active) else $error("read issued during init");
endmodule
bind dcr_regs dcr_regs_monitor dcr_regs_monitor_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .phy_reset(phy_reset), .rd_issue(rd_issue), .init_active(init_active), .bus_16bit(bus_16bit),
  .drive_weak(drive_weak));

/* File: dv/tb_top.sv */
// Self-checking bench of the register bank
`timescale 1ns/10ps
module tb_top
  import dcr_pkg::*;
;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e; logic bw; logic dw;} dcr_row_type;
  localparam logic [31:0] ID = {2'h0, DCR_MODULE_IDENTIFIER, DCR_MAJOR_REVISION, DCR_MINOR_REVISION};
  localparam dcr_row_type ROWS [18] = '{
    '{1'b0, 32'h00, 32'h0, ID, 1'b0, 1'b0},
    '{1'b1, 32'h00, 32'hffff_ffff, ID, 1'b0, 1'b0},
    '{1'b1, 32'h04, 32'h7fff_ffff, 32'h4000_0000, 1'b0, 1'b0},
    '{1'b0, 32'h08, 32'h0, 32'h0053_0a20, 1'b0, 1'b0},
    '{1'b0, 32'h0c, 32'h0, 32'h0000_081e, 1'b0, 1'b0},
    '{1'b0, 32'h20, 32'h0, 32'h0000_00ff, 1'b0, 1'b0},
    '{1'b0, 32'he4, 32'h0, 32'h0000_0026, 1'b0, 1'b0},
    '{1'b1, 32'h10, 32'h1234, 32'h0, 1'b0, 1'b0},
    '{1'b1, 32'h18, 32'hffff_ffff, 32'h0, 1'b0, 1'b0},
    '{1'b1, 32'h08, 32'h0053_8a20, 32'h0053_8a20, 1'b0, 1'b0},
    '{1'b1, 32'h08, 32'h0053_f7ba, 32'h0053_c632, 1'b1, 1'b0},
    '{1'b1, 32'h08, 32'h0057_c632, 32'h0053_c632, 1'b1, 1'b0},
    '{1'b1, 32'h08, 32'h00d3_c632, 32'h00d3_c632, 1'b1, 1'b0},
    '{1'b1, 32'h08, 32'h00d7_c632, 32'h00d7_c632, 1'b1, 1'b1},
    '{1'b1, 32'h10, 32'h1234, 32'h1234, 1'b1, 1'b1},
    '{1'b1, 32'h08, 32'h0053_0632, 32'h0053_0632, 1'b0, 1'b0},
    '{1'b1, 32'h08, 32'h0053_40bc, 32'h0053_0632, 1'b0, 1'b0},
    '{1'b1, 32'h10, 32'h5555, 32'h1234, 1'b0, 1'b0}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        phy_powered = 1'b0;
  logic        phy_locked = 1'b0;
  logic        rd_request = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        rd_issue;
  logic        rd_sample;
  logic        init_active;
  logic        phy_reset;
  logic        bus_16bit;
  logic        drive_weak;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          d5;
  int          d2;
  int          k;
  ////////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock; the single slave's ready is the bus ready
  always #4 clk = ~clk;
  assign hready = hreadyout;
  dcr_regs dcr_regs_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phy_powered(phy_powered), .phy_locked(phy_locked), .rd_request(rd_request), .rd_issue(rd_issue),
    .rd_sample(rd_sample), .init_active(init_active), .phy_reset(phy_reset), .bus_16bit(bus_16bit),
    .drive_weak(drive_weak));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single word transfer; called just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Poll status until the interface reports ready; the wait is bounded
  task automatic wait_rdy;
    k = 0;
    do begin
      xfer(1'b0, 32'h04, 32'h0);
      k++;
    end while (rd[2] !== 1'b1 && k < 400);
    chk(rd, 32'h4000_0004);
  endtask
  // Wait out init, issue one read and count edges from issue to capture
  task automatic lat(output int d);
    k = 0;
    while (init_active !== 1'b0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    rd_request <= 1'b1;
    @(posedge clk);
    rd_request <= 1'b0;
    k = 0;
    while (rd_issue !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    d = 0;
    while (rd_sample !== 1'b1 && d < 50) begin
      @(posedge clk);
      d++;
    end
    chk(32'(k < 50 && d < 50), 32'h1);
  endtask
  // Counts, verdict and end of run
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  // Main sequence: table first, then interface bring-up, latency, init gating and reset
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) begin
        xfer(1'b1, ROWS[i].a, ROWS[i].d);
      end
      xfer(1'b0, ROWS[i].a, 32'h0);
      chk(rd, ROWS[i].e);
      chk(32'({bus_16bit, drive_weak}), 32'({ROWS[i].bw, ROWS[i].dw}));
    end
    phy_powered <= 1'b1;
    phy_locked <= 1'b1;
    xfer(1'b1, 32'he4, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(32'(phy_reset), 32'h0);
    wait_rdy();
    phy_locked <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h4000_0000);
    phy_locked <= 1'b1;
    wait_rdy();
    lat(d5);
    xfer(1'b1, 32'he4, 32'h0000_0002);
    lat(d2);
    chk(32'(d5 - d2), 32'h2);
    // A configuration write restarts init; reads must wait it out
    xfer(1'b1, 32'h08, 32'h0053_0632);
    repeat (2) @(posedge clk);
    chk(32'(init_active), 32'h1);
    rd_request <= 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge clk);
      if (rd_issue === 1'b1) begin
        k++;
      end
    end
    rd_request <= 1'b0;
    chk(32'(k), 32'h0);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 32'h08, 32'h0);
    chk(rd, 32'h0053_0a20);
    chk(32'(phy_reset), 32'h1);
    results();
  end
endmodule
